//--- hw/pic_params.svh
// Constants of the eight-input priority interrupt block.
// Assumes inclusion by bare name; definitions only.
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

`define PIC_NUM_IN      8
`define PIC_FILT_LEN    2
`define PIC_TBL_DEPTH   32
`define PIC_TBL_AW      5
// Port group base: high nibble fixed, straps pick bits 3:2
`define PIC_BASE_HI     4'hC
// Output port offsets
`define PIC_OFS_CLEAR   2'h0
`define PIC_OFS_MASK    2'h1
`define PIC_OFS_CFG     2'h2
// Input port offsets
`define PIC_OFS_POLL    2'h0
`define PIC_OFS_RESP    2'h1
// Configuration port bit positions
`define PIC_CFG_CIN_EN  0
`define PIC_CFG_COUT_EN 1
`define PIC_CFG_FRONT   2
`define PIC_CFG_NOAUTO  3
`define PIC_CFG_VECTOR  4
`define PIC_CFG_POLLEN  5
`define PIC_CFG_GRP_LO  6
`define PIC_CFG_GRP_HI  7
// Reset values
`define PIC_CFG_RESET   8'h03
`define PIC_MASK_RESET  8'h00
`define PIC_LATCH_RESET 8'h00
// Response encodings
`define PIC_RST_OPCODE  8'hC7
`define PIC_NO_REQ      8'hFF

`endif

//--- hw/pic_pkg.sv
// Types of the priority interrupt block.
// Assumes pic_params.svh supplies the numbers.
package pic_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [0:0]
  {
    ST_IDLE   = 1'b0,
    ST_FROZEN = 1'b1
  } resp_state_e;
endpackage : pic_pkg

//--- hw/vector_table.sv
// User-programmed vector lookup table, asynchronous read.
// Assumes the loader writes it before vector mode is enabled.
`timescale 1ns/1ps
`default_nettype none
`include "pic_params.svh"

module vector_table #(
  parameter int DEPTH = `PIC_TBL_DEPTH,
  parameter int AW    = `PIC_TBL_AW
) (
  input  wire logic          i_clock,
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);

  generate
    if (DEPTH != (1 << AW))
    begin : g_bad_depth
      $error("vector_table: DEPTH must equal 2**AW");
    end
  endgenerate

  pic_pkg::byte_t mem [DEPTH];

  always_ff @(posedge i_clock)
  begin
    if (i_wr)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];

endmodule : vector_table
`default_nettype wire

//--- hw/priority_interrupt.sv
// Eight-input priority interrupt controller with port-mapped control.
// Assumes inputs synchronous to i_clock and a one-cycle strobe port master.
//
// Behaviour
// R1: Latch sets on filtered falling request edge
// R2: Eight latches readable, maskable, clearable by ports
// R3: Fixed priority, input zero most urgent
// R4: Vectored response on acknowledge, polling otherwise
// R5: Restart mode drives restart opcode of winner
// R6: Vector mode reads 32x8 table instead
// R7: Joins daisy chain over backplane chain pins
// R8: Chain may route through front connector
// R9: Chain propagation gated by hardware and software
// R10: Three output ports, one or two inputs
// R11: Response input port only when enabled
// R12: Software may hold off or clear inputs
// R13: Base address picked by two straps
// R14: Serviced latch auto-cleared unless disabled
// R15: Mask gates request, latch still sets/reads
// R16: Request needs chain in; chain out dropped
// R17: Freeze request and chain during response
// R18: Response encodes lowest pending enabled index
// R19: Reset clears latches, request deasserted
`timescale 1ns/1ps
`default_nettype none
`include "pic_params.svh"

module priority_interrupt #(
  parameter int NUM_IN   = `PIC_NUM_IN,
  parameter int FILT_LEN = `PIC_FILT_LEN
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [NUM_IN-1:0] i_request_in_n,
  input  wire logic              i_addr_strap_low,
  input  wire logic              i_addr_strap_high,
  input  wire logic [7:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  input  wire logic              i_ack_n,
  input  wire logic              i_freeze,
  output logic      [7:0]        o_ack_data,
  output logic                   o_ack_data_oe,
  output logic                   o_int_req_out,
  output logic                   o_int_req_oe,
  output logic                   o_irq,
  input  wire logic              i_chain_in,
  input  wire logic              i_chain_in_front,
  output logic                   o_chain_out,
  output logic                   o_chain_out_front,
  input  wire logic              i_tbl_wr,
  input  wire logic [4:0]        i_tbl_addr,
  input  wire logic [7:0]        i_tbl_data
);

  generate
    if (NUM_IN != 8 || FILT_LEN < 2)
    begin : g_bad_param
      $error("priority_interrupt: NUM_IN must be 8, FILT_LEN at least 2");
    end
  endgenerate

  logic [1:0]          strap_q;
  logic [NUM_IN-1:0]   filt_q;
  logic [NUM_IN-1:0]   fall;
  logic [NUM_IN-1:0]   latch_q;
  logic [NUM_IN-1:0]   latch_d;
  logic [NUM_IN-1:0]   mask_q;
  logic [7:0]          cfg_q;
  logic                service_q;
  logic                ack_prev_q;
  logic [2:0]          win_q;
  logic                any_q;
  logic [2:0]          win;
  logic                any_pend;
  pic_pkg::resp_state_e state_q;
  pic_pkg::byte_t      tbl_byte;
  pic_pkg::byte_t      resp_byte;

  // R13: strap base decode
  wire [7:0] base      = {`PIC_BASE_HI, strap_q, 2'b00};
  wire       hit       = (i_addr[7:2] == base[7:2]);
  wire [1:0] ofs       = i_addr[1:0];
  wire       wr_clr    = i_wr & hit & (ofs == `PIC_OFS_CLEAR);
  wire       wr_mask   = i_wr & hit & (ofs == `PIC_OFS_MASK);
  wire       wr_cfg    = i_wr & hit & (ofs == `PIC_OFS_CFG);
  wire       rd_poll   = i_rd & hit & (ofs == `PIC_OFS_POLL);
  wire       rd_resp_a = i_rd & hit & (ofs == `PIC_OFS_RESP);
  wire       poll_en   = cfg_q[`PIC_CFG_POLLEN];
  wire       rd_resp   = rd_resp_a & poll_en;

  wire [NUM_IN-1:0] pend  = latch_q & mask_q;
  wire       frz_req      = ~i_ack_n | rd_resp | i_freeze;
  wire       ack_start    = ~i_ack_n & ack_prev_q;
  wire       frozen_st    = (state_q == pic_pkg::ST_FROZEN);
  wire [2:0] resp_win     = frozen_st ? win_q : win;
  wire       resp_any     = frozen_st ? any_q : any_pend;
  wire       serve        = (ack_start | rd_resp) & resp_any;
  wire       auto_on      = ~cfg_q[`PIC_CFG_NOAUTO];
  wire [NUM_IN-1:0] auto_clr = (serve & auto_on) ? (NUM_IN'(1) << resp_win) : '0;
  wire [NUM_IN-1:0] clr_mask = (wr_clr ? i_wdata[NUM_IN-1:0] : '0) | auto_clr;

  // Chain input selection and local request
  wire chain_raw    = cfg_q[`PIC_CFG_FRONT] ? i_chain_in_front : i_chain_in;
  wire chain_in_eff = chain_raw & cfg_q[`PIC_CFG_CIN_EN];
  wire local_req    = any_pend & chain_in_eff;
  wire chain_out_d  = chain_in_eff & ~local_req & ~service_q & cfg_q[`PIC_CFG_COUT_EN];

  wire [4:0] tbl_idx = {cfg_q[`PIC_CFG_GRP_HI:`PIC_CFG_GRP_LO], resp_win};
  wire [7:0] rst_byte = `PIC_RST_OPCODE | {2'b00, resp_win, 3'b000};

  // R5: restart opcode of winner
  // R6: table byte replaces restart
  // R18: lowest pending index encoded
  assign resp_byte = !resp_any ? `PIC_NO_REQ :
                     cfg_q[`PIC_CFG_VECTOR] ? tbl_byte : rst_byte;

  // R3: fixed priority encoder
  always_comb
  begin
    win      = 3'd0;
    any_pend = 1'b0;
    for (int k = NUM_IN - 1; k >= 0; k--)
    begin
      if (pend[k])
      begin
        win      = 3'(k);
        any_pend = 1'b1;
      end
    end
  end

  // R1: hysteresis filter and falling edge
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++)
    begin : g_in
      logic [FILT_LEN-1:0] samp_q;
      wire all_hi = &samp_q;
      wire all_lo = ~|samp_q;
      assign fall[g] = filt_q[g] & all_lo;
      always_ff @(posedge i_clock)
      begin
        if (i_rst)
        begin
          samp_q    <= '1;
          filt_q[g] <= 1'b1;
        end
        else
        begin
          samp_q    <= {samp_q[FILT_LEN-2:0], i_request_in_n[g]};
          filt_q[g] <= all_hi ? 1'b1 : (all_lo ? 1'b0 : filt_q[g]);
        end
      end
    end
  endgenerate

  // R2: set wins over software or auto clear
  // R12: software clear port
  // R14: auto clear of serviced input
  assign latch_d = (latch_q & ~clr_mask) | fall;

  always_ff @(posedge i_clock)
  begin
    strap_q <= {i_addr_strap_high, i_addr_strap_low};
  end

  // R19: reset clears latches and request
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      latch_q    <= `PIC_LATCH_RESET;
      mask_q     <= `PIC_MASK_RESET;
      cfg_q      <= `PIC_CFG_RESET;
      service_q  <= 1'b0;
      ack_prev_q <= 1'b1;
    end
    else
    begin
      latch_q    <= latch_d;
      ack_prev_q <= i_ack_n;
      if (wr_mask)
      begin
        mask_q <= i_wdata[NUM_IN-1:0];
      end
      if (wr_cfg)
      begin
        cfg_q <= i_wdata;
      end
      // R16: service holds chain out until config port write
      service_q <= serve | (service_q & ~wr_cfg);
    end
  end

  // R17: freeze state captures winner
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_q <= pic_pkg::ST_IDLE;
      win_q   <= 3'd0;
      any_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        pic_pkg::ST_IDLE:
        begin
          win_q <= win;
          any_q <= any_pend;
          if (frz_req)
          begin
            state_q <= pic_pkg::ST_FROZEN;
          end
        end
        pic_pkg::ST_FROZEN:
        begin
          if (!frz_req)
          begin
            state_q <= pic_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_q <= pic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Outputs, all registered
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_rdata           <= 8'h00;
      o_ack_data        <= 8'h00;
      o_ack_data_oe     <= 1'b0;
      o_int_req_out     <= 1'b0;
      o_int_req_oe      <= 1'b0;
      o_irq             <= 1'b0;
      o_chain_out       <= 1'b0;
      o_chain_out_front <= 1'b0;
    end
    else
    begin
      // R10: decoded reads; R11: response port gated
      o_rdata       <= rd_poll ? 8'(latch_q) : (rd_resp ? resp_byte : 8'h00);
      // R4: vector byte during acknowledge
      o_ack_data    <= ~i_ack_n ? resp_byte : 8'h00;
      o_ack_data_oe <= ~i_ack_n;
      o_int_req_out <= 1'b0;
      o_irq         <= any_pend;
      // R17: hold request and chain while frozen
      if (!frz_req)
      begin
        // R15: only enabled latches request
        o_int_req_oe      <= local_req;
        // R7: backplane chain out; R8: front copy; R9: gated
        o_chain_out       <= chain_out_d;
        o_chain_out_front <= chain_out_d;
      end
    end
  end

  vector_table #(
    .DEPTH (`PIC_TBL_DEPTH),
    .AW    (`PIC_TBL_AW)
  ) u_table (
    .i_clock (i_clock),
    .i_wr    (i_tbl_wr),
    .i_waddr (i_tbl_addr),
    .i_wdata (i_tbl_data),
    .i_raddr (tbl_idx),
    .o_rdata (tbl_byte)
  );

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  latch_edge_set_a : assert property (fall[3] |=> latch_q[3]) // R1
    else $error("latch did not set on falling edge");
  port_clear_a : assert property (wr_clr && i_wdata[2] && !fall[2] |=> !latch_q[2]) // R2
    else $error("clear port did not clear latch");
  prio_zero_a : assert property (pend[0] |-> win == 3'd0) // R3
    else $error("input zero lost priority");
  ack_drive_a : assert property (!i_ack_n |=> o_ack_data_oe && o_ack_data == $past(resp_byte)) // R4
    else $error("no byte driven on acknowledge");
  restart_byte_a : assert property (!i_ack_n && resp_any && !cfg_q[`PIC_CFG_VECTOR]
                                    |=> o_ack_data == (8'hC7 | {2'b00, $past(resp_win), 3'b000})) // R5
    else $error("wrong restart byte");
  resp_gate_a : assert property (rd_resp_a && !poll_en && !rd_poll |=> o_rdata == 8'h00) // R11
    else $error("response port answered while disabled");
  strap_decode_a : assert property (i_wr && i_addr == {4'hC, strap_q, 2'b01} |=> mask_q == $past(i_wdata)) // R13
    else $error("mask port not at strap base");
  auto_clear_a : assert property (ack_start && resp_any && auto_on && !fall[resp_win] // R14
                                  |=> !latch_q[$past(resp_win)])
    else $error("serviced latch not cleared");
  masked_keep_a : assert property (fall[0] && !mask_q[0] // R15
                                   |=> latch_q[0] && pend[0] == $past(wr_mask && i_wdata[0]))
    else $error("masked latch misbehaved");
  chain_gate_a : assert property (!frz_req && !chain_in_eff |=> !o_int_req_oe && !o_chain_out) // R16
    else $error("request without chain in");
  freeze_hold_a : assert property (frz_req |=> $stable(o_int_req_oe) && $stable(o_chain_out)) // R17
    else $error("request changed while frozen");
  reset_clear_a : assert property (disable iff (1'b0) i_rst |=> latch_q == 8'h00 && !o_int_req_oe) // R19
    else $error("reset left latch or request");

endmodule : priority_interrupt
`default_nettype wire

//--- testbench/proc_card_model.sv
// Processor card model: holds acknowledge low for a chosen count.
// Assumes go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module proc_card_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_go,
  input  wire logic [3:0] i_len,
  output logic            o_ack_n,
  output logic            o_busy
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      cnt_q <= 4'h0;
    else if (i_go)
      cnt_q <= i_len;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
  assign o_busy  = (cnt_q != 4'h0);
  assign o_ack_n = !o_busy;
endmodule : proc_card_model
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of the priority interrupt block.
// Assumes the processor card model answers acknowledge cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic           i_clock = 1'b0;
  logic           i_rst = 1'b1;
  logic [7:0]     req_n = 8'hFF;
  logic [1:0]     strap = 2'b11;
  logic [7:0]     addr = 8'h00;
  logic [7:0]     wdata = 8'h00;
  logic           wr = 1'b0;
  logic           rd = 1'b0;
  logic           chain_in = 1'b1;
  logic           chain_fr = 1'b0;
  logic           freeze = 1'b0;
  logic           tbl_wr = 1'b0;
  logic [4:0]     tbl_addr = 5'h00;
  logic [7:0]     tbl_data = 8'h00;
  logic           go = 1'b0;
  logic [3:0]     len = 4'h1;
  logic           rd_q = 1'b0;
  logic           oe_q = 1'b0;
  logic [7:0]     rdata, ack_data;
  logic           ack_n, ack_oe, req_out, req_oe, irq, chain_out, chain_fo, busy;
  int             n_errors = 0;
  int             total_checks = 0;
  int             cycles = 0;
  int             k, g;
  pic_pkg::byte_t exp_rd[$], exp_ack[$], m, v, ev, ea;

  always #2 i_clock = ~i_clock;

  priority_interrupt dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_request_in_n(req_n),
    .i_addr_strap_low(strap[0]), .i_addr_strap_high(strap[1]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_ack_n(ack_n), .i_freeze(freeze), .o_ack_data(ack_data), .o_ack_data_oe(ack_oe),
    .o_int_req_out(req_out), .o_int_req_oe(req_oe), .o_irq(irq),
    .i_chain_in(chain_in), .i_chain_in_front(chain_fr),
    .o_chain_out(chain_out), .o_chain_out_front(chain_fo),
    .i_tbl_wr(tbl_wr), .i_tbl_addr(tbl_addr), .i_tbl_data(tbl_data)
  );

  proc_card_model partner (
    .i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_len(len), .o_ack_n(ack_n), .o_busy(busy)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Result watcher: read data and acknowledge bytes
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      finish_test();
    end
    if (rd_q)
    begin
      ev = exp_rd.pop_front();
      `CHK("rdata", ev, rdata)
    end
    if (ack_oe && !oe_q)
    begin
      ea = exp_ack.pop_front();
      `CHK("ack_data", ea, ack_data)
    end
    rd_q <= rd;
    oe_q <= ack_oe;
  end

  task automatic wrp(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask : wrp

  task automatic rdp(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
  endtask : rdp

  task automatic pulse(input logic [7:0] b);
    @(posedge i_clock);
    req_n <= ~b;
    repeat (4) @(posedge i_clock);
    req_n <= 8'hFF;
    repeat (4) @(posedge i_clock);
  endtask : pulse

  task automatic lvl(input logic [2:0] e, input logic [2:0] c);
    repeat (3) @(posedge i_clock);
    #1;
    `CHK("irq_reqoe_chain", e, {irq, req_oe, chain_out} & c)
    `CHK("chain_out_front", e[0] & c[0], chain_fo & c[0])
    `CHK("int_req_out", 1'b0, req_out)
  endtask : lvl

  task automatic ack(input pic_pkg::byte_t e);
    exp_ack.push_back(e);
    @(posedge i_clock);
    go <= 1'b1;
    len <= 4'($urandom_range(1, 6));
    @(posedge i_clock);
    go <= 1'b0;
    @(posedge i_clock);
    while (busy) @(posedge i_clock);
    repeat (2) @(posedge i_clock);
  endtask : ack

  task automatic tload(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clock);
    tbl_wr <= 1'b1;
    tbl_addr <= a;
    tbl_data <= d;
    @(posedge i_clock);
    tbl_wr <= 1'b0;
  endtask : tload

  initial
  begin
    void'($urandom(32'h4328B0A5));
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    rdp(8'hCC, 8'h00);
    rdp(8'hCF, 8'h00);
    lvl(3'b001, 3'b111);
    $display("test reset done");
    wrp(8'hCD, 8'hFF);
    wrp(8'hCE, 8'h23);
    pulse(8'h24);
    rdp(8'hCC, 8'h24);
    lvl(3'b110, 3'b111);
    rdp(8'hCD, 8'hD7);
    rdp(8'hCC, 8'h20);
    rdp(8'hCD, 8'hEF);
    rdp(8'hCD, 8'hFF);
    lvl(3'b000, 3'b111);
    wrp(8'hCE, 8'h23);
    lvl(3'b001, 3'b111);
    wrp(8'hCE, 8'h21);
    lvl(3'b000, 3'b111);
    $display("test poll done");
    wrp(8'hCD, 8'h00);
    pulse(8'h01);
    lvl(3'b000, 3'b110);
    rdp(8'hCC, 8'h01);
    wrp(8'hCD, 8'h01);
    lvl(3'b110, 3'b110);
    wrp(8'hCE, 8'h22);
    lvl(3'b100, 3'b111);
    wrp(8'hCE, 8'h23);
    wrp(8'hCC, 8'h01);
    rdp(8'hCC, 8'h00);
    lvl(3'b001, 3'b111);
    $display("test mask done");
    wrp(8'hCD, 8'hFF);
    for (k = 0; k < 8; k++)
    begin
      m = (8'($urandom) | (8'h01 << k)) & ~((8'h01 << k) - 8'h01);
      pulse(m);
      ack(8'hC7 | 8'(k << 3));
      rdp(8'hCC, m & ~(8'h01 << k));
      wrp(8'hCC, 8'hFF);
      wrp(8'hCE, 8'h23);
    end
    $display("test restart done");
    g = $urandom_range(0, 3);
    k = $urandom_range(0, 7);
    v = 8'($urandom);
    tload({g[1:0], k[2:0]}, v);
    tload({~g[1:0], k[2:0]}, ~v);
    wrp(8'hCE, {g[1:0], 6'h13});
    pulse(8'h01 << k);
    ack(v);
    wrp(8'hCE, {g[1:0], 6'h1B});
    pulse(8'h01 << k);
    ack(v);
    rdp(8'hCC, 8'h01 << k);
    wrp(8'hCC, 8'hFF);
    $display("test vector done");
    chain_in <= 1'b0;
    wrp(8'hCE, 8'h03);
    pulse(8'h01);
    lvl(3'b100, 3'b111);
    @(posedge i_clock);
    chain_fr <= 1'b1;
    wrp(8'hCE, 8'h07);
    lvl(3'b110, 3'b111);
    rdp(8'hCD, 8'h00);
    rdp(8'hCC, 8'h01);
    wrp(8'hCC, 8'hFF);
    @(posedge i_clock);
    freeze <= 1'b1;
    pulse(8'h02);
    lvl(3'b101, 3'b111);
    @(posedge i_clock);
    freeze <= 1'b0;
    lvl(3'b110, 3'b111);
    wrp(8'hCC, 8'hFF);
    $display("test chain done");
    @(posedge i_clock);
    strap <= 2'b01;
    pulse(8'h80);
    rdp(8'hC4, 8'h80);
    rdp(8'hCC, 8'h00);
    wrp(8'hC4, 8'h80);
    rdp(8'hC4, 8'h00);
    $display("test straps done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
